// ### hdl/abc_config_regs.sv
// Behaviour
// - Trip level field bits 4:3 forced to 00 while boost is disabled.
// - Trip level 00 disables internal detection; external signal decides safeguard.
// - Trip level 01/10/11 select 3.50V/3.55V/3.60V thresholds; reset 01.
// - Bit 2 enables safeguard mode by software; resets to 0.
// - Bits 1:0 set safeguard ceiling 5.5/5.0/6.0/6.5Vp; reset 00.
// - Boost target 111..100 maps 8.5V..7.75V; reset 101; host avoids 0XX.
// - Coil current limit 000..111 maps 1.50A..4.00A; reset 100.
// - Receiver gain 0000..1000 maps -3.0..9.0dB; reset 0010; host stays below 1001.
// - Boost gain 1001..1111 maps 18.0..27.0dB; reset 1101; host avoids lower codes.
// - Guard register bits 7:5 read 001; other reserved upper bits read zero.
// - Writing 0xaa to the identity register restores all defaults.
`timescale 1ns/1ps
`default_nettype none
module abc_config_regs (
  input wire logic mclk_i, // 200 MHz register clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic wr_en_i, // Register write strobe
  input wire abc_pkg::abc_wr_t wr_req_i, // Write address and data
  input wire logic rd_en_i, // Register read strobe
  input wire logic [7:0] rd_addr_i, // Read address
  input wire logic boost_en_i, // Boost mode select, same clock
  input wire logic ext_guard_i, // Off-chip safeguard signal pin
  input wire logic batt_low_i, // On-chip battery comparator, async
  output logic [7:0] rd_data_o, // Read data
  output logic rd_valid_o, // Read data valid pulse
  output logic [1:0] trip_level_o, // Battery trip threshold code
  output logic int_detect_en_o, // On-chip threshold detect enable
  output logic guard_sw_en_o, // Software safeguard enable
  output logic [1:0] guard_ceiling_o, // Safeguard output ceiling code
  output logic guard_active_o, // Safeguard mode active
  output logic [2:0] boost_volt_o, // Boost target code
  output logic [2:0] coil_limit_o, // Coil peak current code
  output logic [3:0] gain_o // Amplifier gain code
);
  import abc_pkg::*;

  logic ext_s1, ext_s2, low_s1, low_s2;
  logic gain_reload;

  // One strobe matched against one register offset
  function automatic logic addr_hit(input logic en, input logic [7:0] addr, input logic [7:0] offset);
    return en && (addr == offset);
  endfunction

  wire id_hit = addr_hit(wr_en_i, wr_req_i.addr, ID_OFFSET);
  wire soft_rst = id_hit && wr_req_i.data == SOFT_RESET_KEY;
  wire wr_guard = addr_hit(wr_en_i, wr_req_i.addr, GUARD_OFFSET);
  wire wr_volt = addr_hit(wr_en_i, wr_req_i.addr, BOOST_VOLT_OFFSET);
  wire wr_coil = addr_hit(wr_en_i, wr_req_i.addr, COIL_LIMIT_OFFSET);
  wire wr_gain = addr_hit(wr_en_i, wr_req_i.addr, GAIN_OFFSET);

  wire [1:0] wr_trip = wr_req_i.data[TRIP_LSB+1:TRIP_LSB];
  wire [1:0] kept_trip = soft_rst ? TRIP_RESET : (wr_guard ? wr_trip : trip_level_o);
  wire [1:0] next_trip = boost_en_i ? kept_trip : TRIP_OFF;
  wire next_sw_en = soft_rst ? SW_EN_RESET : (wr_guard ? wr_req_i.data[SW_EN_BIT] : guard_sw_en_o);
  wire [1:0] next_ceil = soft_rst ? CEIL_RESET :
    (wr_guard ? wr_req_i.data[CEIL_LSB+1:CEIL_LSB] : guard_ceiling_o);
  wire [2:0] next_volt = soft_rst ? BOOST_VOLT_RESET : (wr_volt ? wr_req_i.data[2:0] : boost_volt_o);
  wire [2:0] next_coil = soft_rst ? COIL_LIMIT_RESET : (wr_coil ? wr_req_i.data[2:0] : coil_limit_o);
  wire [3:0] mode_gain = boost_en_i ? GAIN_BOOST_RESET : GAIN_RCV_RESET;
  wire [3:0] next_gain = gain_reload ? mode_gain : (wr_gain ? wr_req_i.data[3:0] : gain_o);
  // Threshold 00 hands the decision to the off-chip signal
  wire trip_src = (trip_level_o == TRIP_OFF) ? ext_s2 : low_s2;
  wire next_active = guard_sw_en_o || trip_src;

  wire [7:0] guard_rd = {GUARD_RSVD, trip_level_o, guard_sw_en_o, guard_ceiling_o};
  wire sel_guard = addr_hit(1'b1, rd_addr_i, GUARD_OFFSET);
  wire sel_volt = addr_hit(1'b1, rd_addr_i, BOOST_VOLT_OFFSET);
  wire sel_coil = addr_hit(1'b1, rd_addr_i, COIL_LIMIT_OFFSET);
  wire sel_gain = addr_hit(1'b1, rd_addr_i, GAIN_OFFSET);
  // Unmapped offsets and reserved upper bits read as zero, except guard bits 7:5, which read 001
  wire [7:0] next_rd = sel_guard ? guard_rd :
    sel_volt ? {5'h00, boost_volt_o} :
    sel_coil ? {5'h00, coil_limit_o} :
    sel_gain ? {4'h0, gain_o} : 8'h00;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      low_s1 <= 1'b0;
      low_s2 <= 1'b0;
    end else begin
      ext_s1 <= ext_guard_i;
      ext_s2 <= ext_s1;
      low_s1 <= batt_low_i;
      low_s2 <= low_s1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trip_level_o <= TRIP_RESET;
      int_detect_en_o <= 1'b1;
      guard_sw_en_o <= SW_EN_RESET;
      guard_ceiling_o <= CEIL_RESET;
    end else begin
      trip_level_o <= next_trip;
      int_detect_en_o <= next_trip != TRIP_OFF;
      guard_sw_en_o <= next_sw_en;
      guard_ceiling_o <= next_ceil;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_volt_o <= BOOST_VOLT_RESET;
      coil_limit_o <= COIL_LIMIT_RESET;
    end else begin
      boost_volt_o <= next_volt;
      coil_limit_o <= next_coil;
    end
  end

  // Async reset cannot see the mode, so the gain reloads at the first edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gain_o <= GAIN_RCV_RESET;
      gain_reload <= 1'b1;
    end else begin
      gain_o <= next_gain;
      gain_reload <= soft_rst;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      guard_active_o <= 1'b0;
    end else begin
      guard_active_o <= next_active;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_data_o <= next_rd;
      rd_valid_o <= rd_en_i;
    end
  end

  trip_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && !boost_en_i) |=> trip_level_o == TRIP_OFF) else $error("trip level not held at 00");
  ext_select_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (trip_level_o == TRIP_OFF && !guard_sw_en_o && ext_s2) |=> guard_active_o)
    else $error("external signal ignored");
  detect_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ##1 int_detect_en_o == (trip_level_o != TRIP_OFF)) else $error("detect enable mismatch");
  trip_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_guard && boost_en_i) |=> trip_level_o == $past(wr_req_i.data[4:3])) else $error("trip write lost");
  sw_en_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_guard |=> guard_sw_en_o == $past(wr_req_i.data[SW_EN_BIT]))
    else $error("soft enable write lost");
  ceil_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_guard |=> guard_ceiling_o == $past(wr_req_i.data[1:0])) else $error("ceiling write lost");
  volt_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_volt |=> boost_volt_o == $past(wr_req_i.data[2:0])) else $error("boost target write lost");
  coil_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr_coil |=> coil_limit_o == $past(wr_req_i.data[2:0])) else $error("coil limit write lost");
  gain_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr_gain && !gain_reload) |=> gain_o == $past(wr_req_i.data[3:0])) else $error("gain write lost");
  guard_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rd_en_i && rd_addr_i == GUARD_OFFSET) |=> rd_valid_o && rd_data_o[7:5] == 3'h1 &&
    rd_data_o[2] == $past(guard_sw_en_o)) else $error("guard readback wrong");
  soft_defaults_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    soft_rst |=> boost_volt_o == 3'h5 && coil_limit_o == 3'h4 && guard_ceiling_o == 2'h0 && !guard_sw_en_o)
    else $error("soft reset defaults wrong");
  gain_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    soft_rst |=> ##2 gain_o == ($past(boost_en_i) ? GAIN_BOOST_RESET : GAIN_RCV_RESET))
    else $error("gain default wrong");
  gain_reload_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && gain_reload) |=> gain_o == ($past(boost_en_i) ? GAIN_BOOST_RESET : GAIN_RCV_RESET))
    else $error("gain reload ignores mode");
  trip_soft_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (soft_rst && boost_en_i) |=> trip_level_o == TRIP_RESET && int_detect_en_o)
    else $error("trip level not restored");

  // Safeguard source selection
  batt_select_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (trip_level_o != TRIP_OFF && !guard_sw_en_o) |=> guard_active_o == $past(low_s2))
    else $error("battery comparator not followed");
  guard_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (trip_level_o == TRIP_OFF && !guard_sw_en_o && !ext_s2) |=> !guard_active_o)
    else $error("safeguard active without request");
  sw_active_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    guard_sw_en_o |=> guard_active_o)
    else $error("software safeguard not active");

  // Settings hold between writes
  guard_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && !wr_guard && !soft_rst) |=> $stable(guard_ceiling_o) && $stable(guard_sw_en_o))
    else $error("guard setting drifted");
  volt_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && !wr_volt && !soft_rst) |=> $stable(boost_volt_o))
    else $error("boost target drifted");
  coil_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && !wr_coil && !soft_rst) |=> $stable(coil_limit_o))
    else $error("coil limit drifted");
  gain_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rst_b_i && !wr_gain && !gain_reload) |=> $stable(gain_o))
    else $error("gain drifted");

  // Readback of the narrow registers and unmapped offsets, and the read valid pulse
  volt_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rd_en_i && rd_addr_i == BOOST_VOLT_OFFSET) |=> rd_valid_o && rd_data_o == {5'h00, $past(boost_volt_o)})
    else $error("boost target readback wrong");
  coil_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rd_en_i && rd_addr_i == COIL_LIMIT_OFFSET) |=> rd_valid_o && rd_data_o == {5'h00, $past(coil_limit_o)})
    else $error("coil limit readback wrong");
  gain_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rd_en_i && rd_addr_i == GAIN_OFFSET) |=> rd_valid_o && rd_data_o == {4'h0, $past(gain_o)})
    else $error("gain readback wrong");
  blank_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rd_en_i && rd_addr_i > GAIN_OFFSET) |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  rd_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ##1 rd_valid_o == $past(rd_en_i))
    else $error("read valid pulse wrong");
endmodule
`default_nettype wire

// ### hdl/abc_pkg.sv
package abc_pkg;
  // Register offsets
  localparam logic [7:0] ID_OFFSET = 8'h00;
  localparam logic [7:0] GUARD_OFFSET = 8'h02;
  localparam logic [7:0] BOOST_VOLT_OFFSET = 8'h03;
  localparam logic [7:0] COIL_LIMIT_OFFSET = 8'h04;
  localparam logic [7:0] GAIN_OFFSET = 8'h05;
  // Writing this to the identity register restores all defaults
  localparam logic [7:0] SOFT_RESET_KEY = 8'haa;
  // Battery guard field positions and the value read from reserved bits 7:5
  localparam int TRIP_LSB = 3;
  localparam int SW_EN_BIT = 2;
  localparam int CEIL_LSB = 0;
  localparam logic [2:0] GUARD_RSVD = 3'h1;
  // Reset values, and the trip level code that turns on-chip detection off
  localparam logic [1:0] TRIP_RESET = 2'h1;
  localparam logic [1:0] TRIP_OFF = 2'h0;
  localparam logic SW_EN_RESET = 1'b0;
  localparam logic [1:0] CEIL_RESET = 2'h0;
  localparam logic [2:0] BOOST_VOLT_RESET = 3'h5;
  localparam logic [2:0] COIL_LIMIT_RESET = 3'h4;
  localparam logic [3:0] GAIN_RCV_RESET = 4'h2;
  localparam logic [3:0] GAIN_BOOST_RESET = 4'hd;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } abc_wr_t;
endpackage

// ### dv/abc_host.sv
`timescale 1ns/1ps
`default_nettype none
module abc_host (
  input wire logic mclk_i, // Register clock
  input wire logic [7:0] rd_data_i, // Read data
  input wire logic rd_valid_i, // Read data valid
  output logic wr_en_o = 1'b0, // Write strobe
  output abc_pkg::abc_wr_t wr_req_o = '0, // Write address and data
  output logic rd_en_o = 1'b0, // Read strobe
  output logic [7:0] rd_addr_o = 8'h00 // Read address
);
  import abc_pkg::*;
  // Only legal volt and gain codes are written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_en_o <= 1'b1;
    wr_req_o <= '{addr: a, data: d};
    @(posedge mclk_i);
    wr_en_o <= 1'b0;
    wr_req_o <= ~wr_req_o;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge mclk_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a;
    @(posedge mclk_i);
    d = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule
`default_nettype wire

// ### dv/abc_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module abc_config_regs_test;
  import abc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, boost = 1'b1, ext = 1'b0, batt = 1'b0;
  logic wen, ren, rv, det, sw, act, v;
  abc_wr_t req;
  logic [7:0] ra, rdat, d;
  logic [1:0] trip, ceil;
  logic [2:0] volt, coil;
  logic [3:0] gain;
  int bad_count = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  abc_host host (.mclk_i(clk), .rd_data_i(rdat), .rd_valid_i(rv), .wr_en_o(wen), .wr_req_o(req), .rd_en_o(ren),
    .rd_addr_o(ra));
  abc_config_regs dut (.mclk_i(clk), .rst_b_i(rst_b), .wr_en_i(wen), .wr_req_i(req), .rd_en_i(ren), .rd_addr_i(ra),
    .boost_en_i(boost), .ext_guard_i(ext), .batt_low_i(batt), .rd_data_o(rdat), .rd_valid_o(rv), .trip_level_o(trip),
    .int_detect_en_o(det), .guard_sw_en_o(sw), .guard_ceiling_o(ceil), .guard_active_o(act), .boost_volt_o(volt),
    .coil_limit_o(coil), .gain_o(gain));
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk("rd_valid_o", 8'h01, {7'h00, v});
    chk("rd_data_o", e, d);
  endtask
  task automatic guard(input logic [7:0] e);
    repeat (4) @(posedge clk);
    chk("guard_outputs", e, {1'b0, trip, det, sw, ceil, act});
  endtask
  task automatic defaults(input logic [7:0] t, input logic [7:0] g);
    rc(GUARD_OFFSET, t);
    rc(BOOST_VOLT_OFFSET, 8'h05);
    rc(COIL_LIMIT_OFFSET, 8'h04);
    rc(GAIN_OFFSET, g);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    defaults(8'h28, 8'h0d);
    host.wr(GUARD_OFFSET, 8'hff);
    host.wr(BOOST_VOLT_OFFSET, 8'hff);
    host.wr(COIL_LIMIT_OFFSET, 8'hfa);
    host.wr(GAIN_OFFSET, 8'h0f);
    rc(GUARD_OFFSET, 8'h3f);
    rc(BOOST_VOLT_OFFSET, 8'h07);
    rc(COIL_LIMIT_OFFSET, 8'h02);
    rc(GAIN_OFFSET, 8'h0f);
    rc(8'h07, 8'h00);
    chk("volt_coil", 8'h3a, {2'h0, volt, coil});
    guard(8'h7f);
    host.wr(GUARD_OFFSET, 8'h08);
    batt <= 1'b1;
    guard(8'h31);
    host.wr(GUARD_OFFSET, 8'h01);
    ext <= 1'b1;
    guard(8'h03);
    ext <= 1'b0;
    guard(8'h02);
    batt <= 1'b0;
    host.wr(ID_OFFSET, SOFT_RESET_KEY);
    repeat (2) @(posedge clk);
    defaults(8'h28, 8'h0d);
    boost <= 1'b0;
    host.wr(GUARD_OFFSET, 8'h18);
    rc(GUARD_OFFSET, 8'h20);
    host.wr(ID_OFFSET, SOFT_RESET_KEY);
    repeat (2) @(posedge clk);
    defaults(8'h20, 8'h02);
    host.wr(GAIN_OFFSET, 8'h08);
    host.wr(ID_OFFSET, 8'h55);
    rc(GAIN_OFFSET, 8'h08);
    chk("gain_o", 8'h08, {4'h0, gain});
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    defaults(8'h20, 8'h02);
    complete_run();
  end
endmodule
`default_nettype wire
